// ==== jet_tap.sv ====
// Emulation test access port: TAP controller, 8-bit instruction register, one-bit data paths
`timescale 1ns/1ps
`include "jet_map.svh"
module jet_tap #(
  parameter int IR_LEN = `JET_IR_LEN
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic emulation_ctl_pin_a_in,
  output logic emulation_ctl_pin_a_out,
  output logic emulation_ctl_pin_a_oe,
  input wire logic emulation_ctl_pin_b_in,
  output logic emulation_ctl_pin_b_out,
  output logic emulation_ctl_pin_b_oe,
  input wire logic emu_halt_req_a,
  input wire logic emu_halt_req_b,
  output logic emu_seen_a,
  output logic emu_seen_b,
  output logic [IR_LEN-1:0] active_instr,
  output logic vendor_private_instr
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_sync;
  // Reset to idle pin levels so no false edge or pin-low report follows reset
  jet_sync #(
    .WIDTH(6),
    .RESET_VAL(`JET_SYNC_RESET)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({tck, tms, tdi, trst_n, emulation_ctl_pin_a_in, emulation_ctl_pin_b_in}),
    .sync_out(pins_sync)
  );
  logic tck_s, tms_s, tdi_s, trst_n_s;
  assign tck_s = pins_sync[5];
  assign tms_s = pins_sync[4];
  assign tdi_s = pins_sync[3];
  assign trst_n_s = pins_sync[2];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Only the sample, high-impedance and external-test codes reach the dummy cell
  function automatic jet_pkg::jet_sel_type decode_sel(input logic [IR_LEN-1:0] code);
    if (code == `JET_IR_EXTEST || code == `JET_IR_SAMPLE || code == `JET_IR_HIGHZ)
      decode_sel = jet_pkg::JET_SEL_DUMMY;
    else if (code == `JET_IR_PRIV_A || (code >= `JET_IR_PRIV_LO && code <= `JET_IR_PRIV_HI))
      decode_sel = jet_pkg::JET_SEL_PRIVATE;
    else
      decode_sel = jet_pkg::JET_SEL_BYPASS;
  endfunction

  // Dummy cell or one-bit bypass; shift and drive paths must agree
  function automatic logic uses_dummy(input logic [IR_LEN-1:0] code);
    uses_dummy = (decode_sel(code) == jet_pkg::JET_SEL_DUMMY);
  endfunction

  // ----------------------------------------------------------------
  // TAP state and scan registers
  // ----------------------------------------------------------------
  jet_pkg::jet_state_type state_ff, nxt_state;
  logic tck_d_ff, nxt_tck_d;
  logic [IR_LEN-1:0] ir_shift_ff, nxt_ir_shift;
  logic [IR_LEN-1:0] ir_ff, nxt_ir;
  logic bypass_ff, nxt_bypass;
  logic dummy_ff, nxt_dummy;
  logic tdo_ff, nxt_tdo;
  logic tdo_oe_ff, nxt_tdo_oe;
  logic rise, fall;

  // Limitation: a test clock glitch shorter than one system clock may be missed
  // Edges found by the system clock; pin period must be well above 4 cycles
  assign rise = tck_s & ~tck_d_ff;
  assign fall = ~tck_s & tck_d_ff;

  // Next-state and datapath on TCK rising, TDO update on falling
  always_comb begin
    nxt_tck_d = tck_s;
    nxt_state = state_ff;
    nxt_ir_shift = ir_shift_ff;
    nxt_ir = ir_ff;
    nxt_bypass = bypass_ff;
    nxt_dummy = dummy_ff;
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    // Test reset is a level and wins over any edge found in the same cycle
    if (!trst_n_s) begin
      nxt_state = jet_pkg::JET_RESET;
      nxt_ir = `JET_IR_RESET;
      nxt_tdo_oe = 1'b0;
    end else if (rise) begin
      // Sixteen-state walk, advanced only on a found rising edge
      unique case (state_ff)
        jet_pkg::JET_RESET: nxt_state = tms_s ? jet_pkg::JET_RESET : jet_pkg::JET_IDLE;
        jet_pkg::JET_IDLE: nxt_state = tms_s ? jet_pkg::JET_SEL_DR : jet_pkg::JET_IDLE;
        jet_pkg::JET_SEL_DR: nxt_state = tms_s ? jet_pkg::JET_SEL_IR : jet_pkg::JET_CAP_DR;
        jet_pkg::JET_CAP_DR: nxt_state = tms_s ? jet_pkg::JET_EXIT1_DR : jet_pkg::JET_SHIFT_DR;
        jet_pkg::JET_SHIFT_DR: nxt_state = tms_s ? jet_pkg::JET_EXIT1_DR : jet_pkg::JET_SHIFT_DR;
        jet_pkg::JET_EXIT1_DR: nxt_state = tms_s ? jet_pkg::JET_UPD_DR : jet_pkg::JET_PAUSE_DR;
        jet_pkg::JET_PAUSE_DR: nxt_state = tms_s ? jet_pkg::JET_EXIT2_DR : jet_pkg::JET_PAUSE_DR;
        jet_pkg::JET_EXIT2_DR: nxt_state = tms_s ? jet_pkg::JET_UPD_DR : jet_pkg::JET_SHIFT_DR;
        jet_pkg::JET_UPD_DR: nxt_state = tms_s ? jet_pkg::JET_SEL_DR : jet_pkg::JET_IDLE;
        jet_pkg::JET_SEL_IR: nxt_state = tms_s ? jet_pkg::JET_RESET : jet_pkg::JET_CAP_IR;
        jet_pkg::JET_CAP_IR: nxt_state = tms_s ? jet_pkg::JET_EXIT1_IR : jet_pkg::JET_SHIFT_IR;
        jet_pkg::JET_SHIFT_IR: nxt_state = tms_s ? jet_pkg::JET_EXIT1_IR : jet_pkg::JET_SHIFT_IR;
        jet_pkg::JET_EXIT1_IR: nxt_state = tms_s ? jet_pkg::JET_UPD_IR : jet_pkg::JET_PAUSE_IR;
        jet_pkg::JET_PAUSE_IR: nxt_state = tms_s ? jet_pkg::JET_EXIT2_IR : jet_pkg::JET_PAUSE_IR;
        jet_pkg::JET_EXIT2_IR: nxt_state = tms_s ? jet_pkg::JET_UPD_IR : jet_pkg::JET_SHIFT_IR;
        jet_pkg::JET_UPD_IR: nxt_state = tms_s ? jet_pkg::JET_SEL_DR : jet_pkg::JET_IDLE;
      endcase
      // Scan registers; the fixed capture pattern lets a controller size the chain
      unique case (state_ff)
        jet_pkg::JET_RESET: nxt_ir = `JET_IR_RESET;
        jet_pkg::JET_CAP_IR: nxt_ir_shift = `JET_IR_CAPTURE;
        jet_pkg::JET_SHIFT_IR: nxt_ir_shift = {tdi_s, ir_shift_ff[IR_LEN-1:1]};
        jet_pkg::JET_UPD_IR: nxt_ir = ir_shift_ff;
        jet_pkg::JET_CAP_DR: begin
          nxt_bypass = 1'b0;
          nxt_dummy = 1'b0; // Dummy captures nothing from pins
        end
        jet_pkg::JET_SHIFT_DR: begin
          if (uses_dummy(ir_ff))
            nxt_dummy = tdi_s;
          else
            nxt_bypass = tdi_s;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      // Output moves on the fall so the next device in the chain samples it settled
      nxt_tdo_oe = (state_ff == jet_pkg::JET_SHIFT_IR) || (state_ff == jet_pkg::JET_SHIFT_DR);
      if (state_ff == jet_pkg::JET_SHIFT_IR)
        nxt_tdo = ir_shift_ff[0];
      else if (state_ff == jet_pkg::JET_SHIFT_DR)
        nxt_tdo = uses_dummy(ir_ff) ? dummy_ff : bypass_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= jet_pkg::JET_RESET;
      tck_d_ff <= 1'b0;
      ir_shift_ff <= '0;
      ir_ff <= `JET_IR_RESET;
      bypass_ff <= 1'b0;
      dummy_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tck_d_ff <= nxt_tck_d;
      ir_shift_ff <= nxt_ir_shift;
      ir_ff <= nxt_ir;
      bypass_ff <= nxt_bypass;
      dummy_ff <= nxt_dummy;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // ----------------------------------------------------------------
  // Emulation pins
  // ----------------------------------------------------------------
  logic seen_a_ff, nxt_seen_a, seen_b_ff, nxt_seen_b;
  logic priv_ff, nxt_priv;

  // Pin levels seen after sync; private flag only reported, never acted on
  always_comb begin
    nxt_seen_a = ~pins_sync[1];
    nxt_seen_b = ~pins_sync[0];
    nxt_priv = (decode_sel(ir_ff) == jet_pkg::JET_SEL_PRIVATE);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_a_ff <= 1'b0;
      seen_b_ff <= 1'b0;
      priv_ff <= 1'b0;
    end else begin
      seen_a_ff <= nxt_seen_a;
      seen_b_ff <= nxt_seen_b;
      priv_ff <= nxt_priv;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and status outputs
  // ----------------------------------------------------------------
  // Any processor may hold a pin low, so seen need not be our own request
  // Open collector: drive only low, release otherwise
  assign emulation_ctl_pin_a_out = 1'b0;
  assign emulation_ctl_pin_a_oe = emu_halt_req_a;
  assign emulation_ctl_pin_b_out = 1'b0;
  assign emulation_ctl_pin_b_oe = emu_halt_req_b;
  // Status and scan outputs straight from flops
  assign emu_seen_a = seen_a_ff;
  assign emu_seen_b = seen_b_ff;
  assign vendor_private_instr = priv_ff;
  assign active_instr = ir_ff;
  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
endmodule

// ==== jet_map.svh ====
// Constants for the emulation test access port
`ifndef JET_MAP_SVH
`define JET_MAP_SVH
`define JET_IR_LEN 8
`define JET_IR_EXTEST 8'h00
`define JET_IR_SAMPLE 8'h02
`define JET_IR_PRIV_A 8'h03
`define JET_IR_HIGHZ 8'h06
`define JET_IR_PRIV_LO 8'h20
`define JET_IR_PRIV_HI 8'h29
`define JET_IR_BYPASS 8'hFF
`define JET_IR_CAPTURE 8'h01
`define JET_IR_RESET 8'hFF
`define JET_SYNC_RESET 6'h07
`endif

// ==== jet_pkg.sv ====
// Types for the emulation test access port
package jet_pkg;
  typedef enum logic [3:0] {
    JET_RESET, JET_IDLE, JET_SEL_DR, JET_CAP_DR, JET_SHIFT_DR, JET_EXIT1_DR,
    JET_PAUSE_DR, JET_EXIT2_DR, JET_UPD_DR, JET_SEL_IR, JET_CAP_IR,
    JET_SHIFT_IR, JET_EXIT1_IR, JET_PAUSE_IR, JET_EXIT2_IR, JET_UPD_IR
  } jet_state_type;
  typedef enum logic [1:0] {
    JET_SEL_BYPASS, JET_SEL_DUMMY, JET_SEL_PRIVATE
  } jet_sel_type;
endpackage

// ==== jet_sync.sv ====
// Two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ps
module jet_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_sync;

  // First stage read only by the second
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ==== jet_tap_sva.sv ====
// Assertion checker for the emulation test port
`timescale 1ns/1ps
module jet_tap_sva #(
  parameter int IR_LEN = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic emulation_ctl_pin_a_in,
  input wire logic emulation_ctl_pin_a_out,
  input wire logic emulation_ctl_pin_a_oe,
  input wire logic emulation_ctl_pin_b_out,
  input wire logic emulation_ctl_pin_b_oe,
  input wire logic emu_halt_req_a,
  input wire logic emu_halt_req_b,
  input wire logic emu_seen_a,
  input wire logic [IR_LEN-1:0] active_instr,
  input wire logic vendor_private_instr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Pin level must outlast both sync flops before it counts
  sequence pin_a_low_s;
    !emulation_ctl_pin_a_in [*5];
  endsequence
  sequence pin_a_high_s;
    emulation_ctl_pin_a_in [*5];
  endsequence
  // Codes held back by the vendor
  function automatic logic priv(input logic [7:0] c);
    return c == 8'h03 || (c >= 8'h20 && c <= 8'h29);
  endfunction
  // Open collector: the driven level is always low, only the enable moves
  a_pin_a_zero: assert property (!emulation_ctl_pin_a_out) else $error("pin a high");
  a_pin_b_zero: assert property (!emulation_ctl_pin_b_out) else $error("pin b high");
  a_oe_a_req: assert property (emulation_ctl_pin_a_oe == emu_halt_req_a) else $error("pin a pull");
  a_oe_b_req: assert property (emulation_ctl_pin_b_oe == emu_halt_req_b) else $error("pin b pull");
  a_seen_low: assert property (pin_a_low_s |-> emu_seen_a) else $error("low pin unseen");
  a_seen_high: assert property (pin_a_high_s |-> !emu_seen_a) else $error("high pin seen");
  a_priv_flag: assert property (vendor_private_instr == priv($past(active_instr)))
    else $error("private flag wrong");
  a_trst_bypass: assert property ((!trst_n) [*5] |-> !tdo_oe && active_instr == 8'hFF)
    else $error("test reset ignored");
  a_tdo_hold: assert property (tck [*6] |-> $stable(tdo)) else $error("tdo moved in tck high");
endmodule
bind jet_tap jet_tap_sva #(.IR_LEN(IR_LEN)) u_sva (
  .sys_clk(sys_clk),
  .rst(rst),
  .tck(tck),
  .trst_n(trst_n),
  .tdo(tdo),
  .tdo_oe(tdo_oe),
  .emulation_ctl_pin_a_in(emulation_ctl_pin_a_in),
  .emulation_ctl_pin_a_out(emulation_ctl_pin_a_out),
  .emulation_ctl_pin_a_oe(emulation_ctl_pin_a_oe),
  .emulation_ctl_pin_b_out(emulation_ctl_pin_b_out),
  .emulation_ctl_pin_b_oe(emulation_ctl_pin_b_oe),
  .emu_halt_req_a(emu_halt_req_a),
  .emu_halt_req_b(emu_halt_req_b),
  .emu_seen_a(emu_seen_a),
  .active_instr(active_instr),
  .vendor_private_instr(vendor_private_instr)
);

// ==== jet_ctl.sv ====
// Emulation controller model driving the test port pins
`timescale 1ns/1ps
module jet_ctl (
  input wire logic sys_clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // Test clock rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 160 ns test clock; tdo taken at the rise, before the port reacts
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge sys_clk);
    tms <= m;
    tdi <= d;
    repeat (15) @(posedge sys_clk);
    tck <= 1'b1;
    q = tdo;
    repeat (16) @(posedge sys_clk);
    tck <= 1'b0;
  endtask
  // Idle to shift, 16 bits LSB first, then update and back to idle
  task automatic scan(input logic ir, input logic [15:0] din, output logic [15:0] dout);
    logic q;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < 16; i++) begin
      step(i == 15, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// ==== jet_tap_tb.sv ====
// Self-checking bench for the emulation test port
`timescale 1ns/1ps
module jet_tap_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic trst_n = 1'b1;
  logic emu_halt_req_a = 1'b0;
  logic emu_halt_req_b = 1'b0;
  logic ext_a = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, q;
  logic emulation_ctl_pin_a_out, emulation_ctl_pin_a_oe, emulation_ctl_pin_b_out, emulation_ctl_pin_b_oe;
  logic emu_seen_a, emu_seen_b, vendor_private_instr;
  logic [7:0] active_instr;
  logic [15:0] dout;
  logic [31:0] lfsr = 32'h0000_a1b0;
  logic [15:0] exp_q[$];
  logic [15:0] act_q[$];
  logic [7:0] codes [7] = '{8'h00, 8'h02, 8'h06, 8'hFF, 8'h1F, 8'h2A, 8'h5A};
  int fails = 0;
  int num_checks = 0;
  // Pulled-up wire-OR: any party may only pull low
  wire logic emulation_ctl_pin_a_in = !(emulation_ctl_pin_a_oe || ext_a);
  wire logic emulation_ctl_pin_b_in = !emulation_ctl_pin_b_oe;
  always #2.5 sys_clk = ~sys_clk;
  jet_tap DUT (
    .sys_clk(sys_clk),
    .rst(rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .trst_n(trst_n),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .emulation_ctl_pin_a_in(emulation_ctl_pin_a_in),
    .emulation_ctl_pin_a_out(emulation_ctl_pin_a_out),
    .emulation_ctl_pin_a_oe(emulation_ctl_pin_a_oe),
    .emulation_ctl_pin_b_in(emulation_ctl_pin_b_in),
    .emulation_ctl_pin_b_out(emulation_ctl_pin_b_out),
    .emulation_ctl_pin_b_oe(emulation_ctl_pin_b_oe),
    .emu_halt_req_a(emu_halt_req_a),
    .emu_halt_req_b(emu_halt_req_b),
    .emu_seen_a(emu_seen_a),
    .emu_seen_b(emu_seen_b),
    .active_instr(active_instr),
    .vendor_private_instr(vendor_private_instr)
  );
  jet_ctl u_ctl (
    .sys_clk(sys_clk),
    .tdo(tdo),
    .tck(tck),
    .tms(tms),
    .tdi(tdi)
  );
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic note(input logic [15:0] e, input logic [15:0] a);
    exp_q.push_back(e);
    act_q.push_back(a);
  endtask
  task automatic end_of_test();
    fails += exp_q.size(); // Notes never compared count against the run
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watcher: oldest expectation against each result as it lands
  always @(posedge sys_clk) begin
    if (act_q.size() > 0) begin
      num_checks++;
      if (exp_q[0] !== act_q[0]) begin
        $display("MISMATCH t=%0t exp=%h act=%h", $time, exp_q[0], act_q[0]);
        fails++;
      end
      void'(exp_q.pop_front());
      void'(act_q.pop_front());
    end
  end
  // Main sequence; private codes are never loaded
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    note(16'h00ff, {8'h00, active_instr});
    note(16'h0000, {15'd0, tdo_oe});
    u_ctl.step(1'b0, 1'b0, q);
    foreach (codes[i]) begin
      lfsr = nxt(lfsr);
      u_ctl.scan(1'b1, {codes[i], lfsr[7:0]}, dout);
      note({lfsr[7:0], 8'h01}, dout);
      note({8'h00, codes[i]}, {8'h00, active_instr});
      note(16'h0000, {15'd0, vendor_private_instr});
      u_ctl.scan(1'b0, lfsr[23:8], dout);
      note({lfsr[22:8], 1'b0}, dout);
    end
    trst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    note(16'h00ff, {8'h00, active_instr});
    trst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      emu_halt_req_a <= lfsr[0];
      emu_halt_req_b <= lfsr[1];
      ext_a <= lfsr[2];
      repeat (8) @(posedge sys_clk);
      note({15'd0, lfsr[0] | lfsr[2]}, {15'd0, emu_seen_a});
      note({15'd0, lfsr[1]}, {15'd0, emu_seen_b});
    end
    repeat (3) @(posedge sys_clk);
    end_of_test();
  end
  // Watchdog well past the expected run of about 9800 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end
endmodule
